//--- rtl/kiu_pkg.sv
// package for the keyboard interrupt unit: register offsets, field positions,
// reset values and bus encodings shared by the unit and its pin synchroniser.
// assumes a 32-bit AHB-Lite register bus with word-aligned byte addresses.
package kiu_pkg;

  localparam int KIU_PINS = 8;

  // register byte offsets, one aligned word each
  localparam logic [7:0] KIU_OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] KIU_OFS_PIN_ENABLE = 8'h04;
  localparam logic [7:0] KIU_OFS_PIN_DIRECTION = 8'h08;
  localparam logic [7:0] KIU_OFS_PULLUP_ENABLE = 8'h0C;
  localparam logic [7:0] KIU_OFS_PORT_DATA = 8'h10;

  // keyboard_status_control fields
  localparam int KIU_BIT_TRIGGER_SELECT = 0;
  localparam int KIU_BIT_IRQ_MASK = 1;
  localparam int KIU_BIT_ACK = 2;
  localparam int KIU_BIT_PENDING = 3;

  // reset values
  localparam logic [7:0] KIU_RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] KIU_RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] KIU_RST_PULLUP_ENABLE = 8'h00;
  localparam logic [7:0] KIU_RST_PORT_DATA = 8'h00;
  localparam logic KIU_RST_TRIGGER_SELECT = 1'b0;
  localparam logic KIU_RST_IRQ_MASK = 1'b0;
  // pins idle high under their pullups, so the synchroniser starts high
  localparam logic KIU_RST_PIN_LEVEL = 1'b1;

  // AHB-Lite encodings
  localparam logic [1:0] KIU_HTRANS_NONSEQ = 2'h2;
  localparam logic KIU_HRESP_OKAY = 1'b0;

endpackage : kiu_pkg

//--- rtl/kiu_pin_sync.sv
// pin synchroniser for the keyboard interrupt unit: three stages and an output flip-flop per pin,
// the output follows once the second and third stages agree.
// assumes asynchronous pin levels and a single hclk domain.
`timescale 1ns/1ns
`default_nettype none

module kiu_pin_sync
  import kiu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [KIU_PINS-1:0] pin_async,
  output logic [KIU_PINS-1:0] pin_level
);

  genvar gi;

  ////////////////////////////////////////////////////////////////////////////
  // one three-stage chain per pin; stage one feeds only stage two
  generate
    for (gi = 0; gi < KIU_PINS; gi++)
    begin : g_pin
      logic stage1_reg;
      logic stage2_reg;
      logic stage3_reg;

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          stage1_reg <= KIU_RST_PIN_LEVEL;
          stage2_reg <= KIU_RST_PIN_LEVEL;
          stage3_reg <= KIU_RST_PIN_LEVEL;
          pin_level[gi] <= KIU_RST_PIN_LEVEL;
        end
        else
        begin
          stage1_reg <= pin_async[gi];
          stage2_reg <= stage1_reg;
          stage3_reg <= stage2_reg;
          // a single-cycle glitch between stages two and three is not passed on
          if (stage2_reg == stage3_reg)
          begin
            pin_level[gi] <= stage3_reg;
          end
        end
      end
    end
  endgenerate

endmodule : kiu_pin_sync

`default_nettype wire

//--- rtl/kiu_keyboard_irq.sv
// keyboard interrupt unit: eight pin inputs into one shared request latch,
// mask, acknowledge, pin direction, pullup and port data, on AHB-Lite.
// assumes the cpu drives vector_fetch for one cycle when it fetches this
// unit's vector, and the system unit provides break state and clear enable.
//
// What this block does
// - latch a request when an enabled input goes low after all were high
// - edge mode: a fall is ignored while another enabled input is low
// - trigger select 1 makes inputs sensitive to falling edges and low levels
// - edge-and-level mode: request stays while any enabled input is low
// - edge-and-level: request drops after acknowledge and all high, either order
// - a vector fetch acknowledges and clears the latch
// - writing 1 to the acknowledge bit clears the request; it reads zero
// - a falling edge after a software acknowledge latches again
// - reset clears the request and trigger select even with a pin low
// - trigger select 0: edges only, acknowledge clears the latch at once
// - pending flag shows any enabled input asserted in the chosen mode
// - pending flag is readable whatever the mask bit says
// - mask 1 blocks the interrupt request; mask 0 lets it through
// - each of eight enable bits admits its pin; zero ignores it
// - an enabled pin is forced to input; pin reads only when direction is 0
// - an enabled pin gets its pullup regardless of the pullup bits
// - unit works in wait and stop; unmasked request wakes the cpu
// - in break, a software acknowledge clears status only when break clear enable is 1
`timescale 1ns/1ns
`default_nettype none

module kiu_keyboard_irq
  import kiu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [KIU_PINS-1:0] kbd_input_pins,
  output logic [KIU_PINS-1:0] kbd_pin_out,
  output logic [KIU_PINS-1:0] kbd_pin_oe,
  output logic [KIU_PINS-1:0] kbd_pin_pullup,
  input wire logic vector_fetch,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic kbd_irq,
  output logic kbd_wakeup
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [KIU_PINS-1:0] pin_level;
  logic [KIU_PINS-1:0] pin_prev_reg;
  logic [KIU_PINS-1:0] kbd_pin_enable_bits;
  logic [KIU_PINS-1:0] pin_direction_reg;
  logic [KIU_PINS-1:0] pullup_enable_bits;
  logic [KIU_PINS-1:0] port_data_reg;
  logic kbd_trigger_select;
  logic kbd_irq_mask;
  logic latch_reg;
  logic latch_next;
  logic any_low;
  logic all_high_prev;
  logic new_request;
  logic kbd_pending_flag;
  logic kbd_ack_strobe;
  logic clear_allowed;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic addr_take;
  logic wr_now;
  logic [KIU_PINS-1:0] wdata8;
  logic [KIU_PINS-1:0] pin_readback;
  logic [31:0] read_value;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  kiu_pin_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_async(kbd_input_pins),
    .pin_level(pin_level)
  );

  // previous sample of the synchronised pins, for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_prev_reg <= {KIU_PINS{KIU_RST_PIN_LEVEL}};
    end
    else
    begin
      pin_prev_reg <= pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger detection over the enabled pins only
  assign any_low = |(kbd_pin_enable_bits & ~pin_level);
  // disabled pins count as high, so disabling a stuck key frees the others
  assign all_high_prev = &(pin_prev_reg | ~kbd_pin_enable_bits);
  // a new request needs a fall while every enabled pin was high before
  assign new_request = any_low & all_high_prev;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge: vector fetch, or software write guarded by break protection
  assign clear_allowed = !break_state || break_clear_enable;
  assign kbd_ack_strobe = vector_fetch
    || (wr_now && (dp_addr_reg == KIU_OFS_STATUS_CONTROL)
        && hwdata[KIU_BIT_ACK] && clear_allowed);

  // latch: a trigger in the same cycle as an acknowledge wins, none is lost
  always_comb
  begin
    latch_next = latch_reg;
    if (kbd_ack_strobe)
    begin
      latch_next = 1'b0;
    end
    if (new_request)
    begin
      latch_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= latch_next;
    end
  end

  // level mode holds the request while any enabled pin is low, so it only
  // drops after both acknowledge and release, in either order
  assign kbd_pending_flag = latch_reg
    || (kbd_trigger_select && any_low);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and wakeup outputs; the unit keeps running in low-power modes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      kbd_irq <= 1'b0;
      kbd_wakeup <= 1'b0;
    end
    else
    begin
      kbd_irq <= kbd_pending_flag && !kbd_irq_mask;
      kbd_wakeup <= kbd_pending_flag && !kbd_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: an enabled pin is an input with its pullup on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      kbd_pin_out <= KIU_RST_PORT_DATA;
      kbd_pin_oe <= KIU_RST_PIN_DIRECTION;
      kbd_pin_pullup <= KIU_RST_PULLUP_ENABLE;
    end
    else
    begin
      kbd_pin_out <= port_data_reg;
      kbd_pin_oe <= pin_direction_reg & ~kbd_pin_enable_bits;
      // pullups stay off on pins driven as outputs
      kbd_pin_pullup <= kbd_pin_enable_bits
        | (pullup_enable_bits & ~pin_direction_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  assign addr_take = hsel && hready && (htrans == KIU_HTRANS_NONSEQ);
  assign wr_now = dp_valid_reg && dp_write_reg;
  assign wdata8 = hwdata[KIU_PINS-1:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  // reads take one wait state so read data reflect a write just before them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= KIU_HRESP_OKAY;
      hrdata <= 32'h00000000;
    end
    else
    begin
      hresp <= KIU_HRESP_OKAY;
      if (addr_take && !hwrite)
      begin
        hreadyout <= 1'b0;
      end
      else
      begin
        hreadyout <= 1'b1;
      end
      if (dp_valid_reg && !dp_write_reg && !hreadyout)
      begin
        hrdata <= read_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register writes; status bits are never written directly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      kbd_trigger_select <= KIU_RST_TRIGGER_SELECT;
      kbd_irq_mask <= KIU_RST_IRQ_MASK;
    end
    else if (wr_now && (dp_addr_reg == KIU_OFS_STATUS_CONTROL))
    begin
      kbd_trigger_select <= hwdata[KIU_BIT_TRIGGER_SELECT];
      kbd_irq_mask <= hwdata[KIU_BIT_IRQ_MASK];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      kbd_pin_enable_bits <= KIU_RST_PIN_ENABLE;
    end
    else if (wr_now && (dp_addr_reg == KIU_OFS_PIN_ENABLE))
    begin
      kbd_pin_enable_bits <= wdata8;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_direction_reg <= KIU_RST_PIN_DIRECTION;
    end
    else if (wr_now && (dp_addr_reg == KIU_OFS_PIN_DIRECTION))
    begin
      pin_direction_reg <= wdata8;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pullup_enable_bits <= KIU_RST_PULLUP_ENABLE;
    end
    else if (wr_now && (dp_addr_reg == KIU_OFS_PULLUP_ENABLE))
    begin
      pullup_enable_bits <= wdata8;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_data_reg <= KIU_RST_PORT_DATA;
    end
    else if (wr_now && (dp_addr_reg == KIU_OFS_PORT_DATA))
    begin
      port_data_reg <= wdata8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; a pin reads its level only while its direction bit is 0
  assign pin_readback = (port_data_reg & pin_direction_reg)
    | (pin_level & ~pin_direction_reg);

  always_comb
  begin
    read_value = 32'h00000000;
    if (dp_addr_reg == KIU_OFS_STATUS_CONTROL)
    begin
      // acknowledge bit always reads zero
      read_value[KIU_BIT_PENDING] = kbd_pending_flag;
      read_value[KIU_BIT_IRQ_MASK] = kbd_irq_mask;
      read_value[KIU_BIT_TRIGGER_SELECT] = kbd_trigger_select;
    end
    else if (dp_addr_reg == KIU_OFS_PIN_ENABLE)
    begin
      read_value[KIU_PINS-1:0] = kbd_pin_enable_bits;
    end
    else if (dp_addr_reg == KIU_OFS_PIN_DIRECTION)
    begin
      read_value[KIU_PINS-1:0] = pin_direction_reg;
    end
    else if (dp_addr_reg == KIU_OFS_PULLUP_ENABLE)
    begin
      read_value[KIU_PINS-1:0] = pullup_enable_bits;
    end
    else if (dp_addr_reg == KIU_OFS_PORT_DATA)
    begin
      read_value[KIU_PINS-1:0] = pin_readback;
    end
  end

endmodule : kiu_keyboard_irq

`default_nettype wire

//--- verification/kiu_irq_chk.sv
// port checker for the keyboard interrupt unit
// assumes one hclk domain and is bound to the unit from the bench top
`timescale 1ns/1ns
`default_nettype none

module kiu_irq_chk
  import kiu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [KIU_PINS-1:0] kbd_input_pins,
  input wire logic [KIU_PINS-1:0] kbd_pin_oe,
  input wire logic [KIU_PINS-1:0] kbd_pin_pullup,
  input wire logic vector_fetch,
  input wire logic kbd_irq,
  input wire logic kbd_wakeup
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] high_age;
  logic [3:0] quiet_age;
  ////////////////////////////////////////////////////////////////////////////
  // saturating ages since the last low pin and the last ack or bus write;
  // the request may only move shortly after one of those causes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_age <= 4'hF;
      quiet_age <= 4'hF;
    end
    else
    begin
      high_age <= (kbd_input_pins != 8'hFF) ? 4'h0 : high_age + {3'h0, high_age != 4'hF};
      quiet_age <= (vector_fetch || (hsel && htrans == KIU_HTRANS_NONSEQ && hwrite)) ?
        4'h0 : quiet_age + {3'h0, quiet_age != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // a read stalls exactly one cycle
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_resp_okay: assert property (hresp == KIU_HRESP_OKAY)
    else $error("hresp not okay");
  chk_wake_follows: assert property (kbd_wakeup == kbd_irq)
    else $error("wakeup differs from irq");
  chk_read_wait: assert property ($fell(hreadyout) |-> rd_wait)
    else $error("read stall not one cycle");
  chk_oe_pullup: assert property ((kbd_pin_oe & kbd_pin_pullup) == 8'h00)
    else $error("driven pin has pullup");
  chk_irq_cause: assert property (
    $rose(kbd_irq) |-> high_age < 4'h9 || quiet_age < 4'h5)
    else $error("irq rose without cause");
  chk_irq_drop: assert property (
    $fell(kbd_irq) |-> quiet_age < 4'h5 || high_age < 4'h9)
    else $error("irq fell without ack");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !kbd_irq && hreadyout)
    else $error("not quiet after reset");
  chk_rdata_word: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : kiu_irq_chk

`default_nettype wire

//--- verification/kiu_keys.sv
// keys on the unit's pins: a closed key pulls its pin to ground
// assumes pin direction, output and pullup come from the unit
`timescale 1ns/1ns
`default_nettype none

module kiu_keys
  import kiu_pkg::*;
(
  input wire logic hclk,
  input wire logic [KIU_PINS-1:0] pressed,
  input wire logic [KIU_PINS-1:0] pin_oe,
  input wire logic [KIU_PINS-1:0] pin_out,
  input wire logic [KIU_PINS-1:0] pin_pullup,
  output logic [KIU_PINS-1:0] pin
);
  logic [KIU_PINS-1:0] churn = 8'h00;
  // an undriven open pin with its pullup off toggles so it never reads a lucky level
  always @(posedge hclk) churn <= ~churn;
  // the unit driving wins, then a closed key, then pullup or noise
  assign pin = (pin_oe & pin_out) | (~pin_oe & ~pressed & (pin_pullup | churn));
endmodule : kiu_keys

`default_nettype wire

//--- verification/tb_keyboard_interrupt_unit.sv
// self-checking bench for the keyboard interrupt unit with a key model
// assumes a single AHB-Lite slave, hready fed back from hreadyout
`timescale 1ns/1ns
`default_nettype none

module tb_keyboard_interrupt_unit
  import kiu_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, vector_fetch, break_state, break_clear_enable;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pressed, m_en, m_keys, p, p2, r;
  logic m_latch, m_mode, m_mask;
  wire logic hreadyout, hresp, kbd_irq, kbd_wakeup;
  wire logic [31:0] hrdata;
  wire logic [7:0] pins, pin_out, pin_oe, pin_pu;
  int errors, tests_run;
  kiu_keyboard_irq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .kbd_input_pins(pins),
    .kbd_pin_out(pin_out), .kbd_pin_oe(pin_oe), .kbd_pin_pullup(pin_pu),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .kbd_irq(kbd_irq), .kbd_wakeup(kbd_wakeup));
  kiu_keys keys_m (.hclk(hclk), .pressed(pressed), .pin_oe(pin_oe), .pin_out(pin_out),
    .pin_pullup(pin_pu), .pin(pins));
  always #2 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  // one single transfer: hold address phase, then data phase, until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rq);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= KIU_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rq = hrdata;
  endtask : xfer
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : check
  // write, mirrored into the model; a blocked ack leaves the latch alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rq;
    xfer(1'b1, a, {24'h0, d}, rq);
    if (a == KIU_OFS_STATUS_CONTROL)
    begin
      m_mode = d[KIU_BIT_TRIGGER_SELECT];
      m_mask = d[KIU_BIT_IRQ_MASK];
      if (d[KIU_BIT_ACK] && !(break_state && !break_clear_enable))
      begin
        m_latch = 1'b0;
      end
    end
    if (a == KIU_OFS_PIN_ENABLE)
    begin
      m_en = d;
    end
  endtask : wr
  // model of the latch: a new enabled fall, only after all enabled were high;
  // level mode adds held keys to the request but never sets the latch itself
  task automatic keys(input logic [7:0] k);
    if ((k & ~m_keys & m_en) != 0 && (m_keys & m_en) == 0)
    begin
      m_latch = 1'b1;
    end
    m_keys = k;
    pressed <= k;
    repeat (10) @(posedge hclk);
  endtask : keys
  task automatic rd_scr();
    logic [31:0] rq, e;
    e = {28'h0, m_latch | (m_mode & ((m_en & m_keys) != 0)), 1'b0, m_mask, m_mode};
    xfer(1'b0, KIU_OFS_STATUS_CONTROL, 32'h0, rq);
    check("status", e, rq);
    check("irq", {31'h0, e[3] & ~e[1]}, {31'h0, kbd_irq});
    check("wake", {31'h0, e[3] & ~e[1]}, {31'h0, kbd_wakeup});
  endtask : rd_scr
  task automatic fetch();
    @(posedge hclk);
    vector_fetch <= 1'b1;
    @(posedge hclk);
    vector_fetch <= 1'b0;
    m_latch = 1'b0;
    repeat (3) @(posedge hclk);
  endtask : fetch
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    errors++;
    summarize();
  end
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    vector_fetch = 1'b0;
    break_state = 1'b0;
    break_clear_enable = 1'b0;
    pressed = 8'h00;
    m_latch = 1'b0;
    m_mode = 1'b0;
    m_mask = 1'b0;
    m_en = 8'h00;
    m_keys = 8'h00;
    errors = 0;
    tests_run = 0;
    void'($urandom(59627));
    p = 8'($urandom % 8);
    p2 = 8'((p + 1 + $urandom % 7) % 8);
    r = 8'($urandom);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_scr();
    xfer(1'b0, 8'h20, 32'h0, q);
    check("unmapped", 32'h0, q);
    // mask, enable every pin, let the pullups settle, acknowledge, unmask
    wr(KIU_OFS_STATUS_CONTROL, 8'h02);
    wr(KIU_OFS_PIN_ENABLE, 8'hFF);
    repeat (10) @(posedge hclk);
    wr(KIU_OFS_STATUS_CONTROL, 8'h06);
    wr(KIU_OFS_STATUS_CONTROL, 8'h00);
    rd_scr();
    wr(KIU_OFS_PIN_DIRECTION, 8'hFF);
    repeat (2) @(posedge hclk);
    check("oe", 32'h0, {24'h0, pin_oe});
    check("pu", 32'hFF, {24'h0, pin_pu});
    // edge mode: latch, acknowledge, a fall while another key is held
    keys(8'h1 << p);
    rd_scr();
    wr(KIU_OFS_STATUS_CONTROL, 8'h04);
    rd_scr();
    keys(m_keys | (8'h1 << p2));
    rd_scr();
    keys(8'h0);
    keys(8'h1 << p2);
    wr(KIU_OFS_STATUS_CONTROL, 8'h02);
    rd_scr();
    fetch();
    rd_scr();
    // break state: a software clear needs the clear enable
    break_state <= 1'b1;
    keys(8'h0);
    keys(8'h1 << p);
    wr(KIU_OFS_STATUS_CONTROL, 8'h06);
    rd_scr();
    break_clear_enable <= 1'b1;
    wr(KIU_OFS_STATUS_CONTROL, 8'h06);
    rd_scr();
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    keys(8'h0);
    // edge-and-level mode: held keys keep the request until ack and release
    wr(KIU_OFS_STATUS_CONTROL, 8'h01);
    keys(8'h1 << p);
    rd_scr();
    wr(KIU_OFS_STATUS_CONTROL, 8'h05);
    rd_scr();
    keys(m_keys | (8'h1 << p2));
    rd_scr();
    keys(8'h0);
    rd_scr();
    keys(8'h1 << p2);
    keys(8'h0);
    rd_scr();
    fetch();
    rd_scr();
    // a disabled pin is ignored; as an output it shows the port data
    wr(KIU_OFS_STATUS_CONTROL, 8'h00);
    wr(KIU_OFS_PIN_ENABLE, ~(8'h1 << p));
    keys(8'h1 << p);
    rd_scr();
    wr(KIU_OFS_PORT_DATA, r);
    xfer(1'b0, KIU_OFS_PORT_DATA, 32'h0, q);
    check("data", {24'h0, r}, q);
    check("out", {24'h0, r}, {24'h0, pin_out});
    wr(KIU_OFS_PIN_DIRECTION, 8'h00);
    keys(8'h1 << p);
    xfer(1'b0, KIU_OFS_PORT_DATA, 32'h0, q);
    check("pins", {24'h0, ~(8'h1 << p)}, q);
    // mid-run reset with a key held low in level mode
    wr(KIU_OFS_PIN_ENABLE, 8'hFF);
    wr(KIU_OFS_STATUS_CONTROL, 8'h01);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    m_latch = 1'b0;
    m_mode = 1'b0;
    m_mask = 1'b0;
    m_en = 8'h00;
    rd_scr();
    // the held key, enabled again, must not trigger: mode is back to edges
    wr(KIU_OFS_PIN_ENABLE, 8'hFF);
    rd_scr();
    summarize();
  end
endmodule : tb_keyboard_interrupt_unit

bind kiu_keyboard_irq kiu_irq_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .kbd_input_pins(kbd_input_pins), .kbd_pin_oe(kbd_pin_oe), .kbd_pin_pullup(kbd_pin_pullup),
  .vector_fetch(vector_fetch), .kbd_irq(kbd_irq), .kbd_wakeup(kbd_wakeup));

`default_nettype wire
